// *** logic/tsh_pkg.sv ***
// Package: register map, field positions and reset values of the tach status and limit block
package tsh_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CONTROL     = 8'h00;
  localparam logic [7:0] OFF_EVENT_FLAGS = 8'h04;
  localparam logic [7:0] OFF_UPPER_BOUND = 8'h08;
  localparam logic [7:0] OFF_LOWER_BOUND = 8'h0C;

  // ==========================================================================
  // Control register fields
  localparam int CTL_RANGE_IRQ_EN  = 0;
  localparam int CTL_TOGGLE_IRQ_EN = 1;
  localparam int CTL_READY_IRQ_EN  = 2;
  localparam int CTL_READING_MODE  = 10;
  localparam int CTL_EDGE_SEL_LO   = 11;
  localparam int CTL_COUNT_LO      = 16;
  localparam logic [31:0] CTL_WMASK = 32'h0000_1C07;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;

  // ==========================================================================
  // Event flag register fields
  localparam int FLG_RANGE  = 0;
  localparam int FLG_PIN    = 1;
  localparam int FLG_TOGGLE = 2;
  localparam int FLG_READY  = 3;

  // ==========================================================================
  // Limits and counter
  localparam int          COUNT_W     = 16;
  localparam logic [15:0] UPPER_RESET = 16'hFFFF;
  localparam logic [15:0] LOWER_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;

  // Tach edges per measuring interval for edge select codes 0..3
  localparam logic [3:0] EDGES_SEL0 = 4'h2;
  localparam logic [3:0] EDGES_SEL1 = 4'h3;
  localparam logic [3:0] EDGES_SEL2 = 4'h5;
  localparam logic [3:0] EDGES_SEL3 = 4'h9;

  // ==========================================================================
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** logic/tsh_cnt_if.sv ***
// Interface: link between the status block and its rotation counter
`timescale 1ns/1ps
interface tsh_cnt_if;
  logic        mode;
  logic [1:0]  edge_sel;
  logic        tach_edge;
  logic        tach_rise;
  logic        ref_level;
  logic        latch_pulse;
  logic [15:0] latched_count;

  modport ctl (output mode, output edge_sel, output tach_edge, output tach_rise,
               output ref_level, input latch_pulse, input latched_count);
  modport cnt (input mode, input edge_sel, input tach_edge, input tach_rise,
               input ref_level, output latch_pulse, output latched_count);
endinterface

// *** logic/tsh_counter.sv ***
// Rotation counter: counts reference clock pulses per tach interval or tach rising edges
`timescale 1ns/1ps
module tsh_counter (
  input wire logic aclk,
  input wire logic aresetn,
  tsh_cnt_if.cnt   cif
);

  logic        ref_prev_ff;
  logic [3:0]  edge_cnt_ff;
  logic [15:0] count_ff;
  logic [15:0] latched_ff;
  logic        latch_ff;

  wire         ref_rise = cif.ref_level & ~ref_prev_ff;
  wire [3:0]   edges_needed = (cif.edge_sel == 2'h0) ? tsh_pkg::EDGES_SEL0 :
                              (cif.edge_sel == 2'h1) ? tsh_pkg::EDGES_SEL1 :
                              (cif.edge_sel == 2'h2) ? tsh_pkg::EDGES_SEL2 :
                                                       tsh_pkg::EDGES_SEL3;
  wire         cnt_full = (count_ff == tsh_pkg::COUNT_MAX);
  wire         at_end = (edge_cnt_ff != 4'h0) && (4'(edge_cnt_ff + 4'h1) == edges_needed);
  wire         end_hit = cif.mode & cif.tach_edge & at_end;
  wire         restart = cif.mode & cif.tach_edge & ((edge_cnt_ff == 4'h0) | at_end);
  wire         bump = cif.mode ? ref_rise : cif.tach_rise;

  wire [15:0]  nxt_count = restart ? 16'h0000 :
                           (bump & ~cnt_full) ? 16'(count_ff + 16'h0001) : count_ff;
  wire [3:0]   nxt_edge_cnt = !cif.mode ? 4'h0 :
                              restart ? 4'h1 :
                              cif.tach_edge ? 4'(edge_cnt_ff + 4'h1) : edge_cnt_ff;
  // Edge counting mode shows the running count, so its latch follows it each cycle
  wire [15:0]  nxt_latched = (!cif.mode | end_hit) ? count_ff : latched_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_prev_ff <= 1'b0;
      edge_cnt_ff <= 4'h0;
      count_ff    <= 16'h0000;
      latched_ff  <= 16'h0000;
      latch_ff    <= 1'b0;
    end else begin
      ref_prev_ff <= cif.ref_level;
      edge_cnt_ff <= nxt_edge_cnt;
      count_ff    <= nxt_count;
      latched_ff  <= nxt_latched;
      latch_ff    <= end_hit;
    end
  end

  assign cif.latch_pulse   = latch_ff;
  assign cif.latched_count = latched_ff;

  // ==========================================================================
  // Checks
  a_ref_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
    (cif.mode && ref_rise && !restart && !cnt_full) |=> (count_ff == $past(count_ff) + 16'h0001))
    else $error("counter did not advance on reference pulse");
  a_interval_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    end_hit |=> (cif.latch_pulse && count_ff == 16'h0000 && latched_ff == $past(count_ff)))
    else $error("interval end did not latch and restart the count");
  a_edge_mode_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (!cif.mode && cif.tach_rise && !cnt_full) |=> (count_ff == $past(count_ff) + 16'h0001))
    else $error("edge mode count did not follow a rising tach edge");

endmodule

// *** logic/tsh_top.sv ***
// Tach status and limit block: event flags, limits and AXI4-Lite register slave
//
// Behaviour
// - In reference-clock mode, count-ready flag sets at each latch; write one clears.
// - In tach-edge mode the count-ready flag stays zero.
// - Count-ready flag with its enable drives the interrupt output.
// - Toggle flag sets on every tach transition; write one clears.
// - Toggle flag with its enable drives the interrupt output.
// - Status bit shows the current tach input level.
// - Range flag sets when count is above upper or below lower bound.
// - Range flag with its enable drives the interrupt output.
// - Sixteen-bit read-write upper bound, resets to all ones, checked against count.
// - Sixteen-bit lower bound resets to zero; count below it sets range flag.
// - Counter counts reference pulses per tach interval, or tach rising edges.
`timescale 1ns/1ps
module tsh_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              fan_speed_input,
  input  wire logic              slow_reference_clock,
  output logic                   tach_irq,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready
);

  // ==========================================================================
  // State
  logic              awready_ff;
  logic              wready_ff;
  logic              aw_held_ff;
  logic              w_held_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              arready_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  logic [31:0]       ctrl_ff;
  logic [15:0]       upper_ff;
  logic [15:0]       lower_ff;
  logic              pin_ff;
  logic              pin_prev_ff;
  logic              ready_flag_ff;
  logic              toggle_flag_ff;
  logic              range_violation_flag_ff;
  logic              irq_ff;

  tsh_cnt_if cif ();

  tsh_counter u_counter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cif     (cif)
  );

  // ==========================================================================
  // Control fields and counter link
  wire        mode                   = ctrl_ff[tsh_pkg::CTL_READING_MODE];
  wire        range_violation_irq_en = ctrl_ff[tsh_pkg::CTL_RANGE_IRQ_EN];
  wire        toggle_irq_en          = ctrl_ff[tsh_pkg::CTL_TOGGLE_IRQ_EN];
  wire        ready_irq_en           = ctrl_ff[tsh_pkg::CTL_READY_IRQ_EN];
  wire [15:0] latched_rotation_count = cif.latched_count;
  wire        tach_edge              = pin_ff ^ pin_prev_ff;

  assign cif.mode      = mode;
  assign cif.edge_sel  = ctrl_ff[tsh_pkg::CTL_EDGE_SEL_LO +: 2];
  assign cif.tach_edge = tach_edge;
  assign cif.tach_rise = pin_ff & ~pin_prev_ff;
  assign cif.ref_level = slow_reference_clock;

  // ==========================================================================
  // Write channel: address and data are taken independently, then joined
  wire aw_take = awvalid & awready_ff;
  wire w_take  = wvalid & wready_ff;
  wire aw_have = aw_held_ff | aw_take;
  wire w_have  = w_held_ff | w_take;
  // Only a held pair is executed, so a write lands one cycle after both arrive
  wire wr_do   = aw_held_ff & w_held_ff & ~bvalid_ff;

  wire nxt_aw_held = aw_have & ~wr_do;
  wire nxt_w_held  = w_have & ~wr_do;
  wire nxt_bvalid  = wr_do | (bvalid_ff & ~bready);
  wire nxt_awready = ~nxt_aw_held & ~nxt_bvalid;
  wire nxt_wready  = ~nxt_w_held & ~nxt_bvalid;

  wire [ADDR_W-1:0] wa = {awaddr_ff[ADDR_W-1:2], 2'h0};
  wire wsel_ctrl  = (wa == ADDR_W'(tsh_pkg::OFF_CONTROL));
  wire wsel_flags = (wa == ADDR_W'(tsh_pkg::OFF_EVENT_FLAGS));
  wire wsel_upper = (wa == ADDR_W'(tsh_pkg::OFF_UPPER_BOUND));
  wire wsel_lower = (wa == ADDR_W'(tsh_pkg::OFF_LOWER_BOUND));
  wire wsel_any   = wsel_ctrl | wsel_flags | wsel_upper | wsel_lower;
  wire [1:0] nxt_bresp = wsel_any ? tsh_pkg::RESP_OKAY : tsh_pkg::RESP_SLVERR;

  // Byte lane mask from the held strobes
  wire [31:0] lane_mask;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign lane_mask[gi*8 +: 8] = {8{wstrb_ff[gi]}};
    end
  endgenerate

  wire [31:0] merged_ctrl  = (ctrl_ff & ~lane_mask) | (wdata_ff & lane_mask);
  wire [31:0] merged_upper = ({16'h0000, upper_ff} & ~lane_mask) | (wdata_ff & lane_mask);
  wire [31:0] merged_lower = ({16'h0000, lower_ff} & ~lane_mask) | (wdata_ff & lane_mask);

  wire [31:0] nxt_ctrl  = (wr_do & wsel_ctrl) ? (merged_ctrl & tsh_pkg::CTL_WMASK) : ctrl_ff;
  wire [15:0] nxt_upper = (wr_do & wsel_upper) ? merged_upper[15:0] : upper_ff;
  wire [15:0] nxt_lower = (wr_do & wsel_lower) ? merged_lower[15:0] : lower_ff;

  // Write-one clears, only through the low byte lane
  wire [3:0] flag_clr = (wr_do & wsel_flags & wstrb_ff[0]) ? wdata_ff[3:0] : 4'h0;

  // ==========================================================================
  // Event flags
  // latch sets ready
  wire ready_set  = mode & cif.latch_pulse;
  wire toggle_set = tach_edge;
  wire range_set  = (latched_rotation_count > upper_ff) | (latched_rotation_count < lower_ff);

  wire nxt_ready  = mode & (ready_set | (ready_flag_ff & ~flag_clr[tsh_pkg::FLG_READY]));
  wire nxt_toggle = toggle_set | (toggle_flag_ff & ~flag_clr[tsh_pkg::FLG_TOGGLE]);
  wire nxt_range  = range_set | (range_violation_flag_ff & ~flag_clr[tsh_pkg::FLG_RANGE]);

  wire nxt_irq = (ready_flag_ff & ready_irq_en) | (toggle_flag_ff & toggle_irq_en) |
                 (range_violation_flag_ff & range_violation_irq_en);

  // ==========================================================================
  // Read channel
  wire ar_take    = arvalid & arready_ff;
  wire nxt_rvalid = ar_take | (rvalid_ff & ~rready);
  wire nxt_arready = ~nxt_rvalid;

  wire [ADDR_W-1:0] ra = {araddr[ADDR_W-1:2], 2'h0};
  wire rsel_ctrl  = (ra == ADDR_W'(tsh_pkg::OFF_CONTROL));
  wire rsel_flags = (ra == ADDR_W'(tsh_pkg::OFF_EVENT_FLAGS));
  wire rsel_upper = (ra == ADDR_W'(tsh_pkg::OFF_UPPER_BOUND));
  wire rsel_lower = (ra == ADDR_W'(tsh_pkg::OFF_LOWER_BOUND));

  wire [31:0] flags_word = {28'h0000000, ready_flag_ff, toggle_flag_ff, pin_ff,
                            range_violation_flag_ff};
  wire [31:0] ctrl_word  = {latched_rotation_count, ctrl_ff[15:0]};
  wire [31:0] rd_word = rsel_ctrl  ? ctrl_word :
                        rsel_flags ? flags_word :
                        rsel_upper ? {16'h0000, upper_ff} :
                        rsel_lower ? {16'h0000, lower_ff} : 32'h0000_0000;
  wire rsel_any = rsel_ctrl | rsel_flags | rsel_upper | rsel_lower;
  wire [1:0]  rd_resp = rsel_any ? tsh_pkg::RESP_OKAY : tsh_pkg::RESP_SLVERR;

  // ==========================================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= tsh_pkg::RESP_OKAY;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      awaddr_ff  <= aw_take ? awaddr : awaddr_ff;
      wdata_ff   <= w_take ? wdata : wdata_ff;
      wstrb_ff   <= w_take ? wstrb : wstrb_ff;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= wr_do ? nxt_bresp : bresp_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= tsh_pkg::RESP_OKAY;
    end else begin
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= ar_take ? rd_word : rdata_ff;
      rresp_ff   <= ar_take ? rd_resp : rresp_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff                 <= tsh_pkg::CTL_RESET;
      upper_ff                <= tsh_pkg::UPPER_RESET;
      lower_ff                <= tsh_pkg::LOWER_RESET;
      pin_ff                  <= 1'b0;
      pin_prev_ff             <= 1'b0;
      ready_flag_ff           <= 1'b0;
      toggle_flag_ff          <= 1'b0;
      range_violation_flag_ff <= 1'b0;
      irq_ff                  <= 1'b0;
    end else begin
      ctrl_ff                 <= nxt_ctrl;
      upper_ff                <= nxt_upper;
      lower_ff                <= nxt_lower;
      pin_ff                  <= fan_speed_input;
      pin_prev_ff             <= pin_ff;
      ready_flag_ff           <= nxt_ready;
      toggle_flag_ff          <= nxt_toggle;
      range_violation_flag_ff <= nxt_range;
      irq_ff                  <= nxt_irq;
    end
  end

  assign awready  = awready_ff;
  assign wready   = wready_ff;
  assign bvalid   = bvalid_ff;
  assign bresp    = bresp_ff;
  assign arready  = arready_ff;
  assign rvalid   = rvalid_ff;
  assign rdata    = rdata_ff;
  assign rresp    = rresp_ff;
  assign tach_irq = irq_ff;

  // ==========================================================================
  // Checks
  a_ready_on_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode && cif.latch_pulse) |=> ready_flag_ff)
    else $error("count-ready flag missed a latch");
  a_ready_mode_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    !mode |=> !ready_flag_ff)
    else $error("count-ready flag set in edge mode");
  a_ready_irq_out: assert property (@(posedge aclk) disable iff (!aresetn)
    (ready_flag_ff && ready_irq_en) |=> tach_irq)
    else $error("count-ready flag did not raise interrupt");
  a_toggle_on_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(fan_speed_input, 3) != $past(fan_speed_input, 2)) |-> toggle_flag_ff)
    else $error("toggle flag missed a tach transition");
  a_toggle_irq_out: assert property (@(posedge aclk) disable iff (!aresetn)
    (toggle_flag_ff && toggle_irq_en) |=> tach_irq)
    else $error("toggle flag did not raise interrupt");
  a_pin_level_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && rsel_flags) |=> (rdata[tsh_pkg::FLG_PIN] == $past(pin_ff)))
    else $error("status read shows wrong pin level");
  a_range_on_window: assert property (@(posedge aclk) disable iff (!aresetn)
    ((latched_rotation_count > upper_ff) || (latched_rotation_count < lower_ff))
      |=> range_violation_flag_ff)
    else $error("range flag missed an out-of-window count");
  a_range_irq_out: assert property (@(posedge aclk) disable iff (!aresetn)
    (range_violation_flag_ff && range_violation_irq_en) |=> tach_irq)
    else $error("range flag did not raise interrupt");
  a_upper_reset_val: assert property (@(posedge aclk)
    !aresetn |=> (upper_ff == tsh_pkg::UPPER_RESET && lower_ff == tsh_pkg::LOWER_RESET))
    else $error("bounds wrong after reset");
  a_quiet_irq_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ready_flag_ff && !toggle_flag_ff && !range_violation_flag_ff) |=> !tach_irq)
    else $error("interrupt raised with no flag set");
  a_set_beats_clr: assert property (@(posedge aclk) disable iff (!aresetn)
    (toggle_set && flag_clr[tsh_pkg::FLG_TOGGLE]) |=> toggle_flag_ff)
    else $error("clear overrode a same-cycle toggle event");
  a_toggle_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (flag_clr[tsh_pkg::FLG_TOGGLE] && !toggle_set) |=> !toggle_flag_ff)
    else $error("toggle flag not cleared by a written one");
  a_range_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (flag_clr[tsh_pkg::FLG_RANGE] && !range_set) |=> !range_violation_flag_ff)
    else $error("range flag not cleared by a written one");
  a_ready_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (flag_clr[tsh_pkg::FLG_READY] && !ready_set) |=> !ready_flag_ff)
    else $error("count-ready flag not cleared by a written one");

endmodule

// *** verification/tsh_fan_model.sv ***
// Fan model: square-wave tach level and a scaled slow reference clock
`timescale 1ns/1ps
module tsh_fan_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic [7:0] half,
  output logic            tach,
  output logic            ref_clk
);
  logic [7:0] cnt_ff;
  logic [1:0] div_ff;
  logic       tach_ff;

  // ======================
  // Waveforms
  // Reference runs at aclk/4 so that measuring intervals stay short
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff  <= 8'h00;
      div_ff  <= 2'h0;
      tach_ff <= 1'b0;
    end else begin
      div_ff <= div_ff + 2'h1;
      // A stopped fan holds its last level, as a locked rotor would
      if (run && cnt_ff >= half) begin
        cnt_ff  <= 8'h00;
        tach_ff <= ~tach_ff;
      end else if (run) begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end

  assign tach    = tach_ff;
  assign ref_clk = div_ff[1];
endmodule

// *** verification/testbench.sv ***
// Testbench: register bus, flag, limit and interrupt checks of the tach status block
`timescale 1ns/1ps
module testbench;
  logic        aclk;
  logic        aresetn;
  logic        tach;
  logic        ref_clk;
  logic        tach_irq;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        run;
  logic [7:0]  half;
  logic [31:0] rnd;
  int          n_mismatch;
  int          comparisons;
  int          seed;

  tsh_top #(.ADDR_W(8)) uut (
    .aclk(aclk), .aresetn(aresetn), .fan_speed_input(tach), .slow_reference_clock(ref_clk),
    .tach_irq(tach_irq), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready)
  );

  tsh_fan_model fan (
    .aclk(aclk), .aresetn(aresetn), .run(run), .half(half), .tach(tach), .ref_clk(ref_clk)
  );

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // ======================
  // Checking and bus tasks
  task automatic finish_test;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] flags(input logic rng, pin, tog, rdy);
    return {28'h0000000, rdy, tog, pin, rng};
  endfunction

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Both valids are held until their own ready is seen at an edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (i == 64) begin
      n_mismatch++;
      finish_test();
    end else begin
      chk({30'h0, bresp}, {30'h0, er});
    end
  endtask

  task automatic rdr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (i == 64) begin
      n_mismatch++;
      finish_test();
    end else begin
      chk(rdata, ed);
      chk({30'h0, rresp}, {30'h0, er});
    end
  endtask

  // ======================
  // Main sequence
  initial begin
    seed = 48725;
    n_mismatch = 0;
    comparisons = 0;
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    run = 1'b0;
    half = 8'h10;
    idle(3);
    aresetn <= 1'b1;
    rdr(tsh_pkg::OFF_EVENT_FLAGS, flags(0, 0, 0, 0), tsh_pkg::RESP_OKAY);
    rdr(tsh_pkg::OFF_UPPER_BOUND, 32'h0000FFFF, tsh_pkg::RESP_OKAY);
    rdr(tsh_pkg::OFF_LOWER_BOUND, 32'h00000000, tsh_pkg::RESP_OKAY);
    rdr(8'h10, 32'h00000000, tsh_pkg::RESP_SLVERR);
    wr(8'h14, 32'hFFFFFFFF, tsh_pkg::RESP_SLVERR);
    for (int k = 0; k < 3; k++) begin
      rnd = $random(seed);
      wr(tsh_pkg::OFF_UPPER_BOUND, rnd, tsh_pkg::RESP_OKAY);
      rdr(tsh_pkg::OFF_UPPER_BOUND, {16'h0000, rnd[15:0]}, tsh_pkg::RESP_OKAY);
    end
    wr(tsh_pkg::OFF_UPPER_BOUND, 32'h0000FFFF, tsh_pkg::RESP_OKAY);
    // Edge-count mode with a random fan speed
    rnd = $random(seed);
    half <= {4'h1, rnd[3:0]};
    run <= 1'b1;
    idle(200);
    run <= 1'b0;
    idle(5);
    rdr(tsh_pkg::OFF_EVENT_FLAGS, flags(0, tach, 1, 0), tsh_pkg::RESP_OKAY);
    wr(tsh_pkg::OFF_CONTROL, 32'h00000002, tsh_pkg::RESP_OKAY);
    idle(3);
    chk({31'h0, tach_irq}, 32'h00000001);
    wr(tsh_pkg::OFF_EVENT_FLAGS, 32'h00000004, tsh_pkg::RESP_OKAY);
    idle(3);
    chk({31'h0, tach_irq}, 32'h00000000);
    rdr(tsh_pkg::OFF_EVENT_FLAGS, flags(0, tach, 0, 0), tsh_pkg::RESP_OKAY);
    // Count is above zero after the rises, so a zero upper bound trips
    wr(tsh_pkg::OFF_UPPER_BOUND, 32'h00000000, tsh_pkg::RESP_OKAY);
    wr(tsh_pkg::OFF_CONTROL, 32'h00000001, tsh_pkg::RESP_OKAY);
    idle(3);
    chk({31'h0, tach_irq}, 32'h00000001);
    rdr(tsh_pkg::OFF_EVENT_FLAGS, flags(1, tach, 0, 0), tsh_pkg::RESP_OKAY);
    wr(tsh_pkg::OFF_UPPER_BOUND, 32'h0000FFFF, tsh_pkg::RESP_OKAY);
    wr(tsh_pkg::OFF_EVENT_FLAGS, 32'h00000001, tsh_pkg::RESP_OKAY);
    rdr(tsh_pkg::OFF_EVENT_FLAGS, flags(0, tach, 0, 0), tsh_pkg::RESP_OKAY);
    wr(tsh_pkg::OFF_LOWER_BOUND, 32'h0000FFFF, tsh_pkg::RESP_OKAY);
    idle(3);
    rdr(tsh_pkg::OFF_EVENT_FLAGS, flags(1, tach, 0, 0), tsh_pkg::RESP_OKAY);
    wr(tsh_pkg::OFF_LOWER_BOUND, 32'h00000000, tsh_pkg::RESP_OKAY);
    wr(tsh_pkg::OFF_EVENT_FLAGS, 32'h00000001, tsh_pkg::RESP_OKAY);
    idle(3);
    chk({31'h0, tach_irq}, 32'h00000000);
    // Fan toggling every cycle makes the clear meet a toggle event in one cycle
    half <= 8'h00;
    run <= 1'b1;
    wr(tsh_pkg::OFF_EVENT_FLAGS, 32'h00000004, tsh_pkg::RESP_OKAY);
    run <= 1'b0;
    half <= {4'h1, rnd[3:0]};
    idle(5);
    rdr(tsh_pkg::OFF_EVENT_FLAGS, flags(0, tach, 1, 0), tsh_pkg::RESP_OKAY);
    // Reference-count mode over every edge-count code
    for (int s = 0; s < 4; s++) begin
      wr(tsh_pkg::OFF_CONTROL, 32'h00000404 | (s << 11), tsh_pkg::RESP_OKAY);
      run <= 1'b1;
      idle(600);
      run <= 1'b0;
      idle(5);
      rdr(tsh_pkg::OFF_EVENT_FLAGS, flags(0, tach, 1, 1), tsh_pkg::RESP_OKAY);
      chk({31'h0, tach_irq}, 32'h00000001);
      wr(tsh_pkg::OFF_EVENT_FLAGS, 32'h0000000C, tsh_pkg::RESP_OKAY);
      rdr(tsh_pkg::OFF_EVENT_FLAGS, flags(0, tach, 0, 0), tsh_pkg::RESP_OKAY);
    end
    wr(tsh_pkg::OFF_CONTROL, 32'h00000004, tsh_pkg::RESP_OKAY);
    run <= 1'b1;
    idle(200);
    run <= 1'b0;
    idle(5);
    rdr(tsh_pkg::OFF_EVENT_FLAGS, flags(0, tach, 1, 0), tsh_pkg::RESP_OKAY);
    chk({31'h0, tach_irq}, 32'h00000000);
    finish_test();
  end
endmodule
